//--- shared/pim_map.svh
`ifndef PIM_MAP_SVH
`define PIM_MAP_SVH
`define PIM_OFF_STATUS     8'h00
`define PIM_OFF_CTRL       8'h04
`define PIM_OFF_THRESH     8'h08
`define PIM_OFF_GLOBAL     8'h0C
`define PIM_CTRL_RESET     8'hFF
`define PIM_THRESH_RESET   8'h00
`define PIM_GLOBAL_RESET   1'b0
`define PIM_BIT_CRC_GATE   7
`define PIM_BIT_UNLOCK     6
`define PIM_BIT_FILTER     5
`define PIM_BIT_WMARK      4
`define PIM_BIT_CCA        3
`define PIM_BIT_RX         2
`define PIM_BIT_TX         1
`define PIM_BIT_SEQ        0
`define PIM_NUM_SRC        7
`endif

//--- shared/pim_pkg.sv
package pim_pkg;
    typedef logic [7:0] pim_byte_type;
    typedef logic [6:0] pim_src_type;
    typedef enum logic [1:0] {
        PIM_RX_HUNT    = 2'b00,
        PIM_RX_FRAME   = 2'b01,
        PIM_RX_DONE    = 2'b10
    } pim_rx_state_type;
endpackage

//--- rtl/pim_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pim_sync (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire pim_pkg::pim_src_type d,
    output var  pim_pkg::pim_src_type q_rise
);
    import pim_pkg::*;
    pim_src_type s1_reg;
    pim_src_type s2_reg;
    pim_src_type s3_reg;
    pim_src_type q_reg;
    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= 7'h00;
            s2_reg <= 7'h00;
            s3_reg <= 7'h00;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    genvar i;
    generate
        for (i = 0; i < 7; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    q_reg[i] <= 1'b0;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    q_reg[i] <= s3_reg[i];
                end
            end
            assign q_rise[i] = (s2_reg[i] == s3_reg[i]) && s3_reg[i] && !q_reg[i];
        end
    endgenerate
endmodule
`default_nettype wire

//--- rtl/pim_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "pim_map.svh"
module pim_irq_ctrl (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic                  synth_unlock_evt,
    input  wire logic                  filter_reject_evt,
    input  wire logic                  channel_assess_evt,
    input  wire logic                  transmit_done_evt,
    input  wire logic                  sequence_done_evt,
    input  wire logic                  rx_byte_strobe,
    input  wire logic                  rx_frame_start,
    input  wire logic                  rx_last_octet,
    input  wire logic                  frame_check_good,
    output logic                       rx_complete,
    output logic                       rx_rehunt,
    output logic [7:0]                 rx_byte_count,
    output logic                       irq_n
);
    import pim_pkg::*;

    pim_byte_type     ctrl_reg;
    pim_byte_type     thresh_reg;
    logic             global_mask_reg;
    pim_src_type      pend_reg;
    pim_src_type      pend_next;
    pim_src_type      async_rise;
    pim_src_type      evt;
    pim_rx_state_type rx_state_reg;
    logic             rx_complete_reg;
    logic             rx_rehunt_reg;
    logic [7:0]       count_reg;
    logic [31:0]      prdata_reg;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;
    logic             wmark_hit;
    logic             irq_raw;

    // Async radio-side events enter through the synchroniser
    pim_sync pim_sync_i (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({synth_unlock_evt, filter_reject_evt, 1'b0, channel_assess_evt,
                   1'b0, transmit_done_evt, sequence_done_evt}),
        .q_rise  (async_rise)
    );

    assign addr_ok = (paddr == `PIM_OFF_STATUS) || (paddr == `PIM_OFF_CTRL) ||
                     (paddr == `PIM_OFF_THRESH) || (paddr == `PIM_OFF_GLOBAL);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `PIM_CTRL_RESET;
        end else if (wr_en && paddr == `PIM_OFF_CTRL) begin
            ctrl_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thresh_reg <= `PIM_THRESH_RESET;
        end else if (wr_en && paddr == `PIM_OFF_THRESH) begin
            thresh_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_mask_reg <= `PIM_GLOBAL_RESET;
        end else if (wr_en && paddr == `PIM_OFF_GLOBAL) begin
            global_mask_reg <= pwdata[0];
        end
    end

    // Read data registered in setup phase, valid during access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_en) begin
            unique case (paddr)
                `PIM_OFF_STATUS: prdata_reg <= {25'h0000000, pend_reg};
                `PIM_OFF_CTRL:   prdata_reg <= {24'h000000, ctrl_reg};
                `PIM_OFF_THRESH: prdata_reg <= {24'h000000, thresh_reg};
                `PIM_OFF_GLOBAL: prdata_reg <= {31'h00000000, global_mask_reg};
                default:         prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Received byte counter, restarts on each frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 8'h00;
        end else if (rx_frame_start) begin
            count_reg <= 8'h00;
        end else if (rx_byte_strobe) begin
            count_reg <= count_reg + 8'h01;
        end
    end
    assign rx_byte_count = count_reg;
    // Threshold zero disabled, else counter wrap would hit it
    assign wmark_hit = rx_byte_strobe && !rx_frame_start && (thresh_reg != 8'h00) &&
                       ((count_reg + 8'h01) == thresh_reg);

    // Receive completion decision at the last octet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_reg    <= PIM_RX_HUNT;
            rx_complete_reg <= 1'b0;
            rx_rehunt_reg   <= 1'b0;
        end else begin
            rx_complete_reg <= 1'b0;
            rx_rehunt_reg   <= 1'b0;
            unique case (rx_state_reg)
                PIM_RX_HUNT: begin
                    if (rx_frame_start) begin
                        rx_state_reg <= PIM_RX_FRAME;
                    end
                end
                PIM_RX_FRAME: begin
                    if (rx_last_octet) begin
                        if (!ctrl_reg[`PIM_BIT_CRC_GATE] || frame_check_good) begin
                            rx_complete_reg <= 1'b1;
                            rx_state_reg    <= PIM_RX_DONE;
                        end else begin
                            rx_rehunt_reg <= 1'b1;
                            rx_state_reg  <= PIM_RX_HUNT;
                        end
                    end
                end
                PIM_RX_DONE: begin
                    rx_state_reg <= PIM_RX_HUNT;
                end
                default: begin
                    rx_state_reg <= PIM_RX_HUNT;
                end
            endcase
        end
    end
    assign rx_complete = rx_complete_reg;
    assign rx_rehunt   = rx_rehunt_reg;

    // Event vector in status bit order 6..0
    assign evt = {async_rise[6],
                  async_rise[5],
                  wmark_hit,
                  async_rise[3],
                  rx_complete_reg,
                  async_rise[1],
                  async_rise[0]};

    // Sticky pending, write one to clear, set wins over clear
    always_comb begin
        pend_next = pend_reg;
        if (wr_en && paddr == `PIM_OFF_STATUS) begin
            pend_next = pend_reg & ~pwdata[6:0];
        end
        pend_next = pend_next | evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= 7'h00;
        end else begin
            pend_reg <= pend_next;
        end
    end

    assign irq_raw = |(pend_reg & ~ctrl_reg[6:0]) && !global_mask_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !irq_raw;
        end
    end

    sequence s_frame_bad;
        rx_state_reg == PIM_RX_FRAME && rx_last_octet && ctrl_reg[7] && !frame_check_good;
    endsequence

    sequence s_frame_good;
        rx_state_reg == PIM_RX_FRAME && rx_last_octet && ctrl_reg[`PIM_BIT_CRC_GATE] && frame_check_good;
    endsequence

    sequence s_status_clear;
        wr_en && paddr == `PIM_OFF_STATUS;
    endsequence

    a_gate_off_done: assert property (@(posedge pclk) disable iff (!presetn)
        rx_state_reg == PIM_RX_FRAME && rx_last_octet && !ctrl_reg[7] |=> rx_complete && !rx_rehunt)
        else $error("gate off frame not completed");
    a_gate_on_rehunt: assert property (@(posedge pclk) disable iff (!presetn)
        s_frame_bad |=> rx_rehunt && !rx_complete ##0 rx_state_reg == PIM_RX_HUNT)
        else $error("bad check frame not rehunted");
    a_unlock_pend: assert property (@(posedge pclk) disable iff (!presetn)
        async_rise[6] |=> pend_reg[6])
        else $error("unlock not pending");
    a_filter_pend: assert property (@(posedge pclk) disable iff (!presetn)
        async_rise[5] |=> pend_reg[5])
        else $error("filter reject not pending");
    a_wmark_pend: assert property (@(posedge pclk) disable iff (!presetn)
        wmark_hit |=> pend_reg[4] && count_reg == thresh_reg)
        else $error("watermark not pending");
    a_rx_pend: assert property (@(posedge pclk) disable iff (!presetn)
        rx_complete |=> pend_reg[2])
        else $error("receive done not pending");
    a_ctrl_reset: assert property (@(posedge pclk)
        !presetn |=> ctrl_reg == 8'hFF || $past(wr_en))
        else $error("control not reset to ones");
    a_global_block: assert property (@(posedge pclk) disable iff (!presetn)
        global_mask_reg |=> irq_n)
        else $error("global mask did not block");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq_n == !$past(|(pend_reg & ~ctrl_reg[6:0]) && !global_mask_reg))
        else $error("irq line wrong");
    a_gate_on_done: assert property (@(posedge pclk) disable iff (!presetn)
        s_frame_good |=> rx_complete && !rx_rehunt ##0 rx_state_reg == PIM_RX_DONE)
        else $error("good check frame not completed");
    a_cca_pend: assert property (@(posedge pclk) disable iff (!presetn)
        async_rise[`PIM_BIT_CCA] |=> pend_reg[`PIM_BIT_CCA])
        else $error("channel assess not pending");
    a_tx_pend: assert property (@(posedge pclk) disable iff (!presetn)
        async_rise[`PIM_BIT_TX] |=> pend_reg[`PIM_BIT_TX])
        else $error("transmit done not pending");
    a_seq_pend: assert property (@(posedge pclk) disable iff (!presetn)
        async_rise[`PIM_BIT_SEQ] |=> pend_reg[`PIM_BIT_SEQ])
        else $error("sequence done not pending");
    a_rx_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        rx_complete |=> !rx_complete)
        else $error("receive complete longer than one cycle");
    a_rehunt_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        rx_rehunt |=> !rx_rehunt)
        else $error("rehunt longer than one cycle");
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        rx_byte_strobe && !rx_frame_start |=> count_reg == $past(count_reg) + 8'h01)
        else $error("byte count did not step");
    a_thresh_zero_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        thresh_reg == 8'h00 |-> !wmark_hit)
        else $error("watermark hit with zero threshold");
    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `PIM_OFF_CTRL |=> ctrl_reg == $past(pwdata[7:0]))
        else $error("control write lost");
    a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == `PIM_OFF_CTRL |=> prdata == {24'h000000, $past(ctrl_reg)})
        else $error("control read wrong");
    a_thresh_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `PIM_OFF_THRESH |=> thresh_reg == $past(pwdata[7:0]))
        else $error("threshold write lost");
    a_global_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `PIM_OFF_GLOBAL |=> global_mask_reg == $past(pwdata[0]))
        else $error("global mask write lost");
    // Clear and event in one cycle: the event must stay pending
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        s_status_clear |=> (pend_reg & $past(evt)) == $past(evt))
        else $error("event lost under clear");
    a_clear_ones: assert property (@(posedge pclk) disable iff (!presetn)
        s_status_clear |=> (pend_reg & $past(pwdata[6:0] & ~evt)) == 7'h00)
        else $error("status bit not cleared");
    a_masked_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (pend_reg & ~ctrl_reg[6:0]) == 7'h00 |=> irq_n)
        else $error("irq low with nothing unmasked");
    // Each unmasked pending source pulls the line low while the global mask is clear
    genvar k;
    generate
        for (k = 0; k < `PIM_NUM_SRC; k++) begin : g_src_irq
            a_src_unmasked: assert property (@(posedge pclk) disable iff (!presetn)
                pend_reg[k] && !ctrl_reg[k] && !global_mask_reg |=> !irq_n)
                else $error("unmasked pending did not raise irq");
        end
    endgenerate
endmodule
`default_nettype wire

//--- verif/pim_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module pim_src_model (
    input  wire logic pclk,
    output logic      unlock_evt,
    output logic      filter_evt,
    output logic      cca_evt,
    output logic      tx_evt,
    output logic      seq_evt,
    output logic      byte_strobe,
    output logic      frame_start,
    output logic      last_octet,
    output logic      check_good
);
    logic [4:0] ev = 5'h00;
    initial begin
        byte_strobe = 1'b0;
        frame_start = 1'b0;
        last_octet  = 1'b0;
        check_good  = 1'b0;
    end
    assign {seq_evt, tx_evt, cca_evt, filter_evt, unlock_evt} = ev;
    // Level high two cycles, then low long enough to re-arm the edge detect
    task automatic fire(input int i);
        @(posedge pclk) ev <= ev | (5'h01 << i);
        repeat (2) @(posedge pclk);
        ev <= ev & ~(5'h01 << i);
        repeat (4) @(posedge pclk);
    endtask
    task automatic frame(input int n, input logic g);
        @(posedge pclk) frame_start <= 1'b1;
        @(posedge pclk) frame_start <= 1'b0;
        byte_strobe <= 1'b1;
        repeat (n) @(posedge pclk);
        byte_strobe <= 1'b0;
        last_octet  <= 1'b1;
        check_good  <= g;
        @(posedge pclk) last_octet <= 1'b0;
        // Check flag no longer held: show the opposite value
        check_good <= ~g;
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

//--- verif/tb_phy_irq_mask_and_crc_gate.sv
`timescale 1ns/1ps
`default_nettype none
module tb_phy_irq_mask_and_crc_gate;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready, pslverr, irq_n, rx_complete, rx_rehunt;
    logic [31:0] prdata, rd;
    logic [7:0]  cnt;
    logic        u, f, c, t, s, bs, fs, lo, gd;
    int          err_count = 0;
    int          compares = 0;
    int          n_done = 0;
    int          n_hunt = 0;
    int          bitpos[5] = '{6, 5, 3, 1, 0};
    logic [31:0] st;
    pim_src_model pim_src_model_i (.pclk(pclk), .unlock_evt(u), .filter_evt(f), .cca_evt(c), .tx_evt(t),
        .seq_evt(s), .byte_strobe(bs), .frame_start(fs), .last_octet(lo), .check_good(gd));
    pim_irq_ctrl pim_irq_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .synth_unlock_evt(u), .filter_reject_evt(f), .channel_assess_evt(c),
        .transmit_done_evt(t), .sequence_done_evt(s), .rx_byte_strobe(bs), .rx_frame_start(fs),
        .rx_last_octet(lo), .frame_check_good(gd), .rx_complete(rx_complete), .rx_rehunt(rx_rehunt),
        .rx_byte_count(cnt), .irq_n(irq_n));
    initial begin
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (rx_complete === 1'b1) n_done++;
        if (rx_rehunt === 1'b1) n_hunt++;
    end
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        apb(1'b1, a, d, e);
    endtask
    task automatic rdreg(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic x;
        apb(1'b0, a, 32'h0, x);
        chk(nm, e, rd);
    endtask
    initial begin
        #500000;
        $display("Timeout");
        err_count++;
        results();
    end
    initial begin
        logic se;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdreg(8'h04, 32'h0000_00FF, "ctrl reset");
        chk("irq reset", 32'h1, {31'h0, irq_n});
        apb(1'b0, 8'h10, 32'h0, se);
        chk("unmapped err", 32'h1, {31'h0, se});
        chk("unmapped data", 32'h0, rd);
        $display("Test reset done");
        st = 32'h0;
        for (int i = 0; i < 5; i++) begin
            pim_src_model_i.fire(i);
            repeat (4) @(posedge pclk);
            st[bitpos[i]] = 1'b1;
            rdreg(8'h00, st, "status masked");
            chk("irq masked", 32'h1, {31'h0, irq_n});
        end
        for (int k = 0; k < 7; k++) begin
            wr(8'h04, 32'h0000_00FF & ~(32'h1 << k));
            repeat (2) @(posedge pclk);
            chk("irq one mask", {31'h0, ~st[k]}, {31'h0, irq_n});
        end
        wr(8'h04, 32'h0000_0080);
        repeat (2) @(posedge pclk);
        chk("irq unmasked", 32'h0, {31'h0, irq_n});
        wr(8'h0C, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("irq global", 32'h1, {31'h0, irq_n});
        rdreg(8'h0C, 32'h0000_0001, "global read");
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'h0000_007F);
        repeat (2) @(posedge pclk);
        rdreg(8'h00, 32'h0, "status clear");
        chk("irq cleared", 32'h1, {31'h0, irq_n});
        $display("Test events done");
        wr(8'h08, 32'h0000_0003);
        rdreg(8'h08, 32'h0000_0003, "threshold");
        pim_src_model_i.frame(3, 1'b0);
        chk("rehunt", 32'h1, n_hunt);
        chk("no complete", 32'h0, n_done);
        chk("byte count", 32'h3, {24'h0, cnt});
        rdreg(8'h00, 32'h0000_0010, "watermark");
        chk("irq wmark", 32'h0, {31'h0, irq_n});
        wr(8'h00, 32'h0000_007F);
        pim_src_model_i.frame(3, 1'b1);
        chk("complete good", 32'h1, n_done);
        rdreg(8'h00, 32'h0000_0014, "rx status");
        wr(8'h00, 32'h0000_007F);
        wr(8'h04, 32'h0000_0000);
        pim_src_model_i.frame(2, 1'b0);
        chk("complete ungated", 32'h2, n_done);
        chk("rehunt ungated", 32'h1, n_hunt);
        chk("byte count two", 32'h2, {24'h0, cnt});
        rdreg(8'h00, 32'h0000_0004, "rx only");
        $display("Test receive done");
        results();
    end
endmodule
`default_nettype wire
